// >>> aspcs_pkg.sv
// Constants, field layouts and carrier types for the asynchronous serial
// protocol control and status block.
// Assumes a plain register port and a frame engine outside this block.
//
// Summary of operation
// R01: Control bit 6 gates the format error interrupt; error flags set anyway.
// R02: Control bit 7 gates the frame done interrupt; done flags set anyway.
// R03: Software keeps sample position no larger than quanta per bit.
// R04: Zero pulse width code 0 means full bit, else code plus one quanta.
// R05: Shortened zero starts at quantum 0; bit time stays unchanged.
// R06: Only the transmitter uses the pulse width; software keeps it in range.
// R07: Receiver busy enable, bit 16, lets frame reception drive busy bit 9.
// R08: Transmitter busy enable, bit 17, lets frame transmission drive busy.
// R09: Control bit 31 enables the master clock; otherwise it stays low.
// R10: Control bits 30 to 18 read zero; software writes zero.
// R11: Hardware never clears a protocol status flag.
// R12: Writing one to the status clear register clears that flag.
// R13: Writing one to a status bit sets it without raising an interrupt.
// R14: Writing zero to a status bit leaves it unchanged.
// R15: Software clears all status flags before starting a new protocol.
// R16: With both busy enables set, busy is receiver OR transmitter activity.
// R17: Each cycle with an enabled status event gives one interrupt request pulse cycle.

package aspcs_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL      = 8'h3C;
   localparam logic [7:0] OFS_STATUS       = 8'h48;
   localparam logic [7:0] OFS_STATUS_CLEAR = 8'h4C;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h50;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h54;

   // Control register: reset value and writable bits
   localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CONTROL_WR_MASK = 32'h8003_FFFF;

   // Status register: width, busy position, reset value
   localparam int          STATUS_W        = 17;
   localparam int          BUSY_BIT        = 9;
   localparam int          STOP_A_ERR_BIT  = 5;
   localparam int          STOP_B_ERR_BIT  = 6;
   localparam int          RX_DONE_BIT     = 7;
   localparam int          TX_DONE_BIT     = 8;
   localparam logic [16:0] STATUS_RESET    = 17'h0_0000;

   // Interrupt pending and mask layout
   localparam int          IRQ_W           = 2;
   localparam int          IRQ_FMT_BIT     = 0;
   localparam int          IRQ_FRAME_BIT   = 1;
   localparam logic [1:0]  IRQ_RESET       = 2'h0;

   // Pulse width code meaning a full-length zero
   localparam logic [2:0]  PULSE_FULL      = 3'h0;
   localparam logic        LINE_IDLE       = 1'h1;

   // Control register layout
   typedef struct packed {
      logic        mclk_enable;
      logic [12:0] reserved;
      logic        tx_activity_busy_enable;
      logic        rx_activity_busy_enable;
      logic [2:0]  zero_pulse_width;
      logic [4:0]  sample_position;
      logic        frame_done_irq_enable;
      logic        format_error_irq_enable;
      logic [5:0]  low_control;
   } aspcs_ctrl_t;

   // One transmit bit as seen at quantum granularity
   typedef struct packed {
      logic       bit_value;
      logic [4:0] quantum_index;
   } aspcs_tx_bit_t;

endpackage : aspcs_pkg

// >>> aspcs_pulse_shaper.sv
// Transmit line shaper: shortens zero bits to a programmed pulse width.
// Assumes the frame engine supplies each bit value with its quantum index.
`timescale 1ns/1ps

module aspcs_pulse_shaper (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire aspcs_pkg::aspcs_tx_bit_t tx_bit,
   input  wire logic [2:0]              zero_pulse_width,
   output logic                         tx_line
);

   logic in_pulse;
   logic next_line;

   // Low portion covers quanta 0 up to the code value, so code plus one
   // quanta; the bit time itself is the engine's and is not touched
   assign in_pulse  = (tx_bit.quantum_index <= {2'h0, zero_pulse_width}); // R04 R05
   assign next_line = tx_bit.bit_value ? 1'b1 :
                      (zero_pulse_width == aspcs_pkg::PULSE_FULL) ? 1'b0 :
                      !in_pulse;                                    // R04

   // Registered so the line never glitches between quanta
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_line <= aspcs_pkg::LINE_IDLE;
      end else begin
         tx_line <= next_line;
      end
   end

endmodule : aspcs_pulse_shaper

// >>> aspcs_mclk_gen.sv
// Master clock generator: divides the system clock when enabled.
// Assumes the enable comes from a register in the same clock domain.
`timescale 1ns/1ps

module aspcs_mclk_gen #(
   parameter int HALF_PERIOD = 2
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic enable,
   output logic      mclk
);

   localparam int CW = (HALF_PERIOD > 1) ? $clog2(HALF_PERIOD) : 1;

   logic [CW-1:0] count;
   logic          wrap;

   initial begin
      if (HALF_PERIOD < 1) begin
         $error("aspcs_mclk_gen: HALF_PERIOD must be at least 1");
      end
   end

   assign wrap = (count == CW'(HALF_PERIOD - 1));

   // Disabled generator is held low and its divider parked at zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         mclk  <= 1'b0;
      end else if (!enable) begin
         count <= '0;
         mclk  <= 1'b0;                                             // R09
      end else begin
         count <= wrap ? '0 : count + CW'(1);
         mclk  <= wrap ? !mclk : mclk;
      end
   end

endmodule : aspcs_mclk_gen

// >>> aspcs_ctrl.sv
// Protocol control and status registers of the asynchronous serial mode,
// with busy indication, interrupt gating, zero pulse shaping and master
// clock. Assumes a frame engine that reports events as one-cycle pulses
// at status bit positions and activity as levels.
`timescale 1ns/1ps

module aspcs_ctrl #(
   parameter int MCLK_HALF_PERIOD = 2
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   // Register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [31:0]                  reg_rdata,
   // Frame engine side
   input  wire logic [16:0]             hw_flag_set,
   input  wire logic                    rx_active,
   input  wire logic                    tx_active,
   input  wire aspcs_pkg::aspcs_tx_bit_t tx_bit,
   output logic [5:0]                   low_control,
   output logic [4:0]                   sample_position,
   // Line and system side
   output logic                         tx_line,
   output logic                         mclk,
   output logic                         irq,
   output logic                         proto_irq_pulse
);

   initial begin
      if (MCLK_HALF_PERIOD < 1) begin
         $error("aspcs_ctrl: MCLK_HALF_PERIOD must be at least 1");
      end
   end

   // Address match, used for every register select
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [31:0]                 control;
   aspcs_pkg::aspcs_ctrl_t      ctrl;
   logic [16:0]                 status;
   logic [1:0]                  irq_pending;
   logic [1:0]                  irq_mask;

   logic [31:0]                 next_control;
   logic [16:0]                 next_status;
   logic [1:0]                  next_irq_pending;
   logic [1:0]                  next_irq_mask;
   logic                        next_irq_pulse;
   logic [31:0]                 next_rdata;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   logic sel_control;
   logic sel_status;
   logic sel_clear;
   logic sel_irq_status;
   logic sel_irq_mask;
   logic sel_any;

   assign sel_control    = hit(reg_addr, aspcs_pkg::OFS_CONTROL);
   assign sel_status     = hit(reg_addr, aspcs_pkg::OFS_STATUS);
   assign sel_clear      = hit(reg_addr, aspcs_pkg::OFS_STATUS_CLEAR);
   assign sel_irq_status = hit(reg_addr, aspcs_pkg::OFS_IRQ_STATUS);
   assign sel_irq_mask   = hit(reg_addr, aspcs_pkg::OFS_IRQ_MASK);
   assign sel_any        = sel_control | sel_status | sel_clear |
                           sel_irq_status | sel_irq_mask;

   logic wr_control;
   logic wr_status;
   logic wr_clear;
   logic wr_irq_status;
   logic wr_irq_mask;

   assign wr_control    = reg_wr & sel_control;
   assign wr_status     = reg_wr & sel_status;
   assign wr_clear      = reg_wr & sel_clear;
   assign wr_irq_status = reg_wr & sel_irq_status;
   assign wr_irq_mask   = reg_wr & sel_irq_mask;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   assign ctrl            = aspcs_pkg::aspcs_ctrl_t'(control);
   assign low_control     = ctrl.low_control;
   // The receiver gets the sample position but never the pulse width
   assign sample_position = ctrl.sample_position;                   // R06

   // Reserved bits never store, so they read back as zero
   assign next_control = wr_control ?
                         (reg_wdata & aspcs_pkg::CONTROL_WR_MASK) :
                         control;                                   // R10

   // ------------------------------------------------------------------
   // Busy indication
   // ------------------------------------------------------------------
   // Busy is a live view of activity; it is never a stored flag, so an
   // enable cleared mid-frame drops the bit at once
   logic rx_busy;
   logic tx_busy;
   logic busy;

   assign rx_busy = ctrl.rx_activity_busy_enable & rx_active;       // R07
   assign tx_busy = ctrl.tx_activity_busy_enable & tx_active;       // R08
   assign busy    = rx_busy | tx_busy;                              // R16

   // ------------------------------------------------------------------
   // Protocol status flags
   // ------------------------------------------------------------------
   // Busy is not a sticky flag and takes neither set nor clear
   localparam logic [16:0] STICKY_MASK =
      ~(17'h0_0001 << aspcs_pkg::BUSY_BIT);

   logic [16:0] hw_set;
   logic [16:0] sw_set;
   logic [16:0] sw_clear;
   logic [16:0] status_view;

   assign hw_set   = hw_flag_set & STICKY_MASK;
   // Ones set flags, zeros do nothing
   assign sw_set   = wr_status ? (reg_wdata[16:0] & STICKY_MASK)
                               : 17'h0_0000;                        // R13 R14
   assign sw_clear = wr_clear ? (reg_wdata[16:0] & STICKY_MASK)
                              : 17'h0_0000;                         // R12

   // Only a clear register write removes a flag; a hardware event in
   // the clearing cycle survives because the set is applied last
   assign next_status = ((status & ~sw_clear) | sw_set) | hw_set;   // R11 R12

   assign status_view = (status & STICKY_MASK) |
                        ({16'h0000, busy} << aspcs_pkg::BUSY_BIT);

   // ------------------------------------------------------------------
   // Interrupt gating
   // ------------------------------------------------------------------
   // Only hardware events qualify, so software setting a status bit
   // never raises a request
   logic fmt_event;
   logic frame_event;
   logic [1:0] irq_set;
   logic [1:0] irq_clear;

   assign fmt_event   = ctrl.format_error_irq_enable &
                        (hw_set[aspcs_pkg::STOP_A_ERR_BIT] |
                         hw_set[aspcs_pkg::STOP_B_ERR_BIT]);        // R01 R13
   assign frame_event = ctrl.frame_done_irq_enable &
                        (hw_set[aspcs_pkg::RX_DONE_BIT] |
                         hw_set[aspcs_pkg::TX_DONE_BIT]);           // R02 R13

   assign irq_set[aspcs_pkg::IRQ_FMT_BIT]   = fmt_event;
   assign irq_set[aspcs_pkg::IRQ_FRAME_BIT] = frame_event;
   assign irq_clear = wr_irq_status ? reg_wdata[1:0] : 2'h0;

   // Write one clears; a new event in the same cycle wins
   assign next_irq_pending = (irq_pending & ~irq_clear) | irq_set;
   assign next_irq_mask    = wr_irq_mask ? reg_wdata[1:0] : irq_mask;
   assign next_irq_pulse   = |irq_set;                              // R17

   // Level output follows the pending bits the mask lets through
   assign irq = |(irq_pending & irq_mask);

   // ------------------------------------------------------------------
   // Read data, valid only in the cycle after the read strobe
   // ------------------------------------------------------------------
   logic [31:0] read_mux;

   assign read_mux =
      sel_control    ? control :
      sel_status     ? {15'h0000, status_view} :
      sel_irq_status ? {30'h0000_0000, irq_pending} :
      sel_irq_mask   ? {30'h0000_0000, irq_mask} :
                       32'h0000_0000;

   // Clear register and unmapped addresses read as zero
   assign next_rdata = (reg_rd & sel_any) ? read_mux : 32'h0000_0000;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         control <= aspcs_pkg::CONTROL_RESET;
         status  <= aspcs_pkg::STATUS_RESET;
      end else begin
         control <= next_control;
         status  <= next_status;
      end
   end

   // Interrupt state and read port
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pending     <= aspcs_pkg::IRQ_RESET;
         irq_mask        <= aspcs_pkg::IRQ_RESET;
         proto_irq_pulse <= 1'b0;
         reg_rdata       <= 32'h0000_0000;
      end else begin
         irq_pending     <= next_irq_pending;
         irq_mask        <= next_irq_mask;
         proto_irq_pulse <= next_irq_pulse;
         reg_rdata       <= next_rdata;
      end
   end

   // ------------------------------------------------------------------
   // Line side
   // ------------------------------------------------------------------
   // Transmitter alone uses the zero pulse width
   aspcs_pulse_shaper u_shaper (
      .sys_clk          (sys_clk),
      .rst_n            (rst_n),
      .tx_bit           (tx_bit),
      .zero_pulse_width (ctrl.zero_pulse_width),                    // R06
      .tx_line          (tx_line)
   );

   aspcs_mclk_gen #(
      .HALF_PERIOD (MCLK_HALF_PERIOD)
   ) u_mclk (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .enable  (ctrl.mclk_enable),                                  // R09
      .mclk    (mclk)
   );

endmodule : aspcs_ctrl

// >>> aspcs_ctrl_asserts.sv
// Checker: interrupt pulse, line shaping, busy view, mclk, read data.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/1ps

module aspcs_ctrl_asserts #(
   parameter int MCLK_HALF_PERIOD = 2
) (
   input wire logic                     sys_clk,
   input wire logic                     rst_n,
   input wire logic [7:0]               reg_addr,
   input wire logic [31:0]              reg_wdata,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic [31:0]              reg_rdata,
   input wire logic [16:0]              hw_flag_set,
   input wire logic                     rx_active,
   input wire logic                     tx_active,
   input wire aspcs_pkg::aspcs_tx_bit_t tx_bit,
   input wire logic                     tx_line,
   input wire logic                     mclk,
   input wire logic                     proto_irq_pulse
);
   aspcs_pkg::aspcs_ctrl_t c;
   logic                   mclk_en_d;
   logic                   busy_q;
   logic                   fe;
   logic                   ff;
   logic                   zlow;

   // Qualified events and the low part of a zero bit
   assign fe   = |hw_flag_set[6:5] & c.format_error_irq_enable;
   assign ff   = |hw_flag_set[8:7] & c.frame_done_irq_enable;
   assign zlow = c.zero_pulse_width == aspcs_pkg::PULSE_FULL ||
                 tx_bit.quantum_index <= {2'h0, c.zero_pulse_width};

   // Shadow of control built from bus writes; busy taken at the read edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         c         <= aspcs_pkg::CONTROL_RESET;
         mclk_en_d <= 1'b0;
         busy_q    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == aspcs_pkg::OFS_CONTROL) begin
            c <= reg_wdata & aspcs_pkg::CONTROL_WR_MASK;
         end
         mclk_en_d <= c.mclk_enable;
         busy_q    <= (c.rx_activity_busy_enable & rx_active) |
                      (c.tx_activity_busy_enable & tx_active);
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   property p_fmt_irq; fe |=> proto_irq_pulse; endproperty
   a_fmt_irq: assert property (p_fmt_irq)
      else $error("format event gave no pulse");
   property p_frm_irq; ff |=> proto_irq_pulse; endproperty
   a_frm_irq: assert property (p_frm_irq)
      else $error("frame event gave no pulse");
   property p_no_pulse; !fe && !ff |=> !proto_irq_pulse; endproperty
   a_no_pulse: assert property (p_no_pulse)
      else $error("pulse without an enabled event");
   property p_mclk_off; !c.mclk_enable && !mclk_en_d |-> !mclk; endproperty
   a_mclk_off: assert property (p_mclk_off)
      else $error("master clock moves while disabled");
   property p_tx_one; tx_bit.bit_value |=> tx_line; endproperty
   a_tx_one: assert property (p_tx_one)
      else $error("one bit not high on line");
   property p_tx_low; !tx_bit.bit_value && zlow |=> !tx_line; endproperty
   a_tx_low: assert property (p_tx_low)
      else $error("zero pulse too short");
   property p_tx_high; !tx_bit.bit_value && !zlow |=> tx_line; endproperty
   a_tx_high: assert property (p_tx_high)
      else $error("zero pulse too long");
   property p_rsvd;
      reg_rd && reg_addr == aspcs_pkg::OFS_CONTROL |=> reg_rdata[30:18] == 13'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved control bits not zero");
   property p_busy;
      reg_rd && reg_addr == aspcs_pkg::OFS_STATUS |=> reg_rdata[9] == busy_q;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy bit wrong");

   c_fmt: cover property (fe ##1 proto_irq_pulse);
   c_short: cover property (!tx_bit.bit_value && !zlow);
   c_busy: cover property (reg_rd && reg_addr == aspcs_pkg::OFS_STATUS && rx_active);
endmodule : aspcs_ctrl_asserts

bind aspcs_ctrl aspcs_ctrl_asserts #(.MCLK_HALF_PERIOD(MCLK_HALF_PERIOD)) u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .hw_flag_set(hw_flag_set), .rx_active(rx_active),
   .tx_active(tx_active), .tx_bit(tx_bit), .tx_line(tx_line), .mclk(mclk),
   .proto_irq_pulse(proto_irq_pulse));

// >>> aspcs_frame_model.sv
// Frame engine stand-in: one-bit frames on command, events as pulses.
// Assumes commands come as one-cycle pulses while the engine is idle.
`timescale 1ns/1ps

module aspcs_frame_model #(
   parameter int QPB = 8
) (
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic               go_tx,
   input  wire logic               go_rx,
   input  wire logic               tx_val,
   input  wire logic               rx_err,
   output aspcs_pkg::aspcs_tx_bit_t tx_bit,
   output logic [16:0]             flag_set,
   output logic                    rx_active,
   output logic                    tx_active
);
   logic [4:0] rq;

   // Index stops at QPB-1 so any legal pulse width fits inside the bit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_bit    <= {aspcs_pkg::LINE_IDLE, 5'h00};
         flag_set  <= 17'h0_0000;
         rx_active <= 1'b0;
         tx_active <= 1'b0;
         rq        <= 5'h00;
      end else begin
         flag_set <= 17'h0_0000;
         if (go_tx) begin
            tx_active <= 1'b1;
            tx_bit    <= {tx_val, 5'h00};
         end else if (tx_active && tx_bit.quantum_index == 5'(QPB - 1)) begin
            tx_active   <= 1'b0;
            tx_bit      <= {aspcs_pkg::LINE_IDLE, 5'h00};
            flag_set[8] <= 1'b1;
         end else if (tx_active) begin
            tx_bit.quantum_index <= tx_bit.quantum_index + 5'h01;
         end
         if (go_rx) begin
            rx_active <= 1'b1;
            rq        <= 5'h00;
         end else if (rx_active && rq == 5'(QPB - 1)) begin
            rx_active   <= 1'b0;
            flag_set[7] <= 1'b1;
            flag_set[5] <= rx_err;
         end else if (rx_active) begin
            rq <= rq + 5'h01;
         end
      end
   end
endmodule : aspcs_frame_model

// >>> tb.sv
// Self-checking bench: register port, events, busy, line shaping, mclk.
// Assumes the checker binds itself to the block top.
`timescale 1ns/1ps

module tb;
   localparam int         HP  = 2;
   localparam int         QPB = 8;
   localparam logic [7:0] A_CTL = aspcs_pkg::OFS_CONTROL;
   localparam logic [7:0] A_ST  = aspcs_pkg::OFS_STATUS;
   localparam logic [7:0] A_CLR = aspcs_pkg::OFS_STATUS_CLEAR;
   localparam logic [7:0] A_IRQ = aspcs_pkg::OFS_IRQ_STATUS;
   localparam logic [7:0] A_MSK = aspcs_pkg::OFS_IRQ_MASK;

   logic        sys_clk, rst_n, reg_wr, reg_rd, rx_active, tx_active;
   logic        tx_line, mclk, irq, go_tx, go_rx, tx_val, rx_err;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [16:0] flag_set;
   logic [5:0]  low_control;
   logic [4:0]  sample_position;
   aspcs_pkg::aspcs_tx_bit_t tx_bit;
   int          mismatches, cmp_count, low_n;

   aspcs_ctrl #(.MCLK_HALF_PERIOD(HP)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .hw_flag_set(flag_set), .rx_active(rx_active),
      .tx_active(tx_active), .tx_bit(tx_bit), .low_control(low_control),
      .sample_position(sample_position), .tx_line(tx_line), .mclk(mclk),
      .irq(irq), .proto_irq_pulse());
   aspcs_frame_model #(.QPB(QPB)) u_model (
      .sys_clk(sys_clk), .rst_n(rst_n), .go_tx(go_tx), .go_rx(go_rx),
      .tx_val(tx_val), .rx_err(rx_err), .tx_bit(tx_bit),
      .flag_set(flag_set), .rx_active(rx_active), .tx_active(tx_active));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Low cycles of the shaped line, seen before the edge updates it
   always @(posedge sys_clk) begin
      if (tx_line === 1'b0) low_n++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, e);
      @(posedge sys_clk);
   endtask : rd

   // One frame; busy is read while the frame is still running
   task automatic run_frame(input logic is_tx, input logic v, input logic b);
      go_tx  <= is_tx;
      go_rx  <= !is_tx;
      tx_val <= v;
      @(posedge sys_clk);
      go_tx <= 1'b0;
      go_rx <= 1'b0;
      rd(A_ST, {22'h0, b, 9'h0}, 32'h0000_0200);
      #1;
      for (int i = 0; i < 40 && (rx_active || tx_active); i++) begin
         @(posedge sys_clk);
         #1;
      end
      repeat (2) @(posedge sys_clk);
   endtask : run_frame

   task automatic t_regs;
      rd(A_CTL, aspcs_pkg::CONTROL_RESET);
      rd(A_IRQ, 32'h0);
      wr(A_CTL, 32'hFFFF_E7FF);
      rd(A_CTL, 32'h8003_E7FF);
      chk({26'h0, low_control}, 32'h3F);
      chk({27'h0, sample_position}, 32'h07);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0);
      wr(A_CTL, 32'h0);
   endtask : t_regs

   task automatic t_status;
      wr(A_MSK, 32'h3);
      wr(A_ST, 32'h0001_0320);
      rd(A_ST, 32'h0001_0120);
      rd(A_IRQ, 32'h0);
      wr(A_ST, 32'h0);
      repeat (20) @(posedge sys_clk);
      rd(A_ST, 32'h0001_0120);
      wr(A_CLR, 32'h20);
      rd(A_ST, 32'h0001_0100);
      rd(A_CLR, 32'h0);
      wr(A_CLR, 32'h0001_FFFF);
      rd(A_ST, 32'h0);
   endtask : t_status

   task automatic t_irq;
      wr(A_CTL, 32'h40);
      rx_err <= 1'b1;
      run_frame(1'b0, 1'b1, 1'b0);
      rd(A_ST, 32'hA0);
      rd(A_IRQ, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(A_MSK, 32'h0);
      #1;
      chk({31'h0, irq}, 32'h0);
      wr(A_MSK, 32'h3);
      wr(A_IRQ, 32'h1);
      rd(A_IRQ, 32'h0);
      wr(A_CTL, 32'h80);
      run_frame(1'b0, 1'b1, 1'b0);
      rd(A_IRQ, 32'h2);
      wr(A_IRQ, 32'h3);
      wr(A_CLR, 32'h0001_FFFF);
      rx_err <= 1'b0;
   endtask : t_irq

   task automatic t_busy;
      for (int en = 0; en < 4; en++) begin
         wr(A_CTL, 32'(en) << 16);
         run_frame(1'b0, 1'b1, en[0]);
         run_frame(1'b1, 1'b1, en[1]);
      end
   endtask : t_busy

   task automatic t_pulse;
      for (int code = 0; code < 8; code++) begin
         wr(A_CTL, 32'(code) << 13);
         low_n = 0;
         run_frame(1'b1, 1'b0, 1'b0);
         chk(low_n, (code == 0) ? QPB : code + 1);
      end
      low_n = 0;
      run_frame(1'b1, 1'b1, 1'b0);
      chk(low_n, 0);
   endtask : t_pulse

   task automatic t_mclk;
      int   n;
      logic prev;
      wr(A_CTL, 32'h8000_0000);
      repeat (4) @(posedge sys_clk);
      #1;
      prev = mclk;
      n = 0;
      repeat (20) begin
         @(posedge sys_clk);
         #1;
         if (mclk !== prev) n++;
         prev = mclk;
      end
      chk(n, 20 / HP);
      wr(A_CTL, 32'h0);
      repeat (3) @(posedge sys_clk);
      n = 0;
      repeat (10) begin
         @(posedge sys_clk);
         #1;
         if (mclk !== 1'b0) n++;
      end
      chk(n, 0);
   endtask : t_mclk

   task automatic end_sim;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   initial begin
      rst_n      = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 32'h0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      go_tx      = 1'b0;
      go_rx      = 1'b0;
      tx_val     = 1'b1;
      rx_err     = 1'b0;
      mismatches = 0;
      cmp_count  = 0;
      low_n      = 0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_status();
      t_irq();
      t_busy();
      t_pulse();
      t_mclk();
      end_sim();
   end

   // Tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      end_sim();
   end
endmodule : tb
